// ### c8bd_bench.sv
/*
 * Self-checking bench for c8bd_top with a far-side model on the serial input.
 * Assumes the design package and modules are compiled first.
 */
`timescale 1ns/1ps
module c8bd_bench;
	logic clk_sys = 1'b0;
	logic rst, tx_valid, special_char_select, rx_ready;
	logic [7:0] tx_data, rx_data;
	logic tx_ready, tx_serial, tx_frame, tx_disp, rx_serial;
	logic rx_special, rx_code_err, rx_valid, rx_aligned, rx_disp, rx_lost;
	int miscompares = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [9:0] w;
	int lost;
	logic low_seen;
	// {k, byte, char at rd-, char at rd+, end rd from -, end rd from +}
	logic [30:0] tab [0:6] = '{
		{1'b1, 8'he1, 10'h0fa, 10'h0fa, 2'h3}, {1'b0, 8'h07, 10'h38b, 10'h074, 2'h2},
		{1'b1, 8'he2, 10'h305, 10'h305, 2'h0}, {1'b0, 8'h07, 10'h38b, 10'h074, 2'h2},
		{1'b0, 8'h00, 10'h274, 10'h18b, 2'h1}, {1'b1, 8'hbc, 10'h0fa, 10'h305, 2'h2},
		{1'b1, 8'hff, 10'h0fa, 10'h305, 2'h2}};

	always #20 clk_sys = ~clk_sys;

	c8bd_top dut (.clk_sys(clk_sys), .rst(rst), .tx_data(tx_data), .special_char_select(special_char_select),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_serial(tx_serial), .tx_frame(tx_frame), .tx_disp(tx_disp),
		.rx_serial(rx_serial), .rx_data(rx_data), .rx_special(rx_special), .rx_code_err(rx_code_err),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_aligned(rx_aligned), .rx_disp(rx_disp), .rx_lost(rx_lost));
	c8bd_remote rem (.clk_sys(clk_sys), .rst(rst), .rx_serial(rx_serial));

	task automatic report_and_stop;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			report_and_stop();
		end
	end

	task automatic check(string what, logic [9:0] seen, logic [9:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic send(logic k, logic [7:0] b);
		logic ok;
		tx_valid <= 1'b1;
		tx_data <= b;
		special_char_select <= k;
		do begin
			@(negedge clk_sys);
			ok = tx_ready;
			@(posedge clk_sys);
		end while (!ok);
	endtask : send

	// Character on tx_serial with disparity before and after it
	task automatic get_char(output logic [9:0] c, output logic s, output logic e);
		s = tx_disp;
		do begin
			@(posedge clk_sys);
			#1;
			if (!tx_frame)
				s = tx_disp;
		end while (!tx_frame);
		e = tx_disp;
		c = {9'h0, tx_serial};
		repeat (9) begin
			@(posedge clk_sys);
			#1;
			c = {c[8:0], tx_serial};
		end
	endtask : get_char

	// Marker D5.2 first, so the case's character is the one after it
	task automatic tx_case(logic [30:0] t);
		logic [9:0] c;
		logic s, e;
		fork
			begin
				send(1'b0, 8'h45);
				send(t[30], t[29:22]);
				tx_valid <= 1'b0;
			end
			begin
				repeat (4) begin
					get_char(c, s, e);
					if (c == 10'h295)
						break;
				end
				check("tx marker", c, 10'h295);
				get_char(c, s, e);
			end
		join
		check("tx char", c, s ? t[11:2] : t[21:12]);
		check("tx disp", {9'h0, e}, {9'h0, s ? t[0] : t[1]});
		$display("test tx %h done", t[29:22]);
	endtask : tx_case

	task automatic rx_word(output logic [9:0] v);
		do @(negedge clk_sys); while (!rx_valid);
		v = {rx_code_err, rx_special, rx_data};
		@(posedge clk_sys);
	endtask : rx_word

	initial begin
		rst = 1'b1;
		tx_valid = 1'b0;
		tx_data = 8'h00;
		special_char_select = 1'b0;
		rx_ready = 1'b1;
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		check("reset outputs", {4'h0, tx_ready, tx_disp, rx_valid, rx_aligned, rx_disp, rx_lost}, 10'h020);
		@(posedge clk_sys);
		rst <= 1'b0;
		$display("test reset done");
		foreach (tab[i])
			tx_case(tab[i]);
		repeat (40) @(posedge clk_sys);
		#1;
		check("rx aligned", {9'h0, rx_aligned}, 10'h001);
		rem.q.push_back(10'h295);
		rem.q.push_back(10'h0fa);
		rem.q.push_back(10'h274);
		rem.q.push_back(10'h274);
		repeat (12) begin
			rx_word(w);
			if (w == 10'h045)
				break;
		end
		check("rx data", w, 10'h045);
		rx_word(w);
		check("rx special", {1'b0, w[8:0]}, 10'h1bc);
		rx_word(w);
		check("rx violation", {9'h0, w[9]}, 10'h001);
		rx_word(w);
		check("rx after violation", w, 10'h000);
		check("rx disp", {9'h0, rx_disp}, 10'h000);
		$display("test rx done");
		@(posedge clk_sys);
		rx_ready <= 1'b0;
		tx_valid <= 1'b1;
		tx_data <= 8'h45;
		special_char_select <= 1'b0;
		lost = 0;
		low_seen = 1'b0;
		repeat (45) begin
			@(posedge clk_sys);
			#1;
			lost += rx_lost;
			low_seen |= !tx_ready;
		end
		check("rx held", {9'h0, rx_valid}, 10'h001);
		check("rx lost", {9'h0, lost != 0}, 10'h001);
		check("tx full", {9'h0, low_seen}, 10'h001);
		@(posedge clk_sys);
		rx_ready <= 1'b1;
		tx_valid <= 1'b0;
		repeat (40) @(posedge clk_sys);
		#1;
		check("tx drained", {9'h0, tx_ready}, 10'h001);
		$display("test buffers done");
		report_and_stop();
	end
endmodule : c8bd_bench

// ### c8bd_buf.sv
/*
 * Two-entry buffer with valid and ready on both sides; all outputs registered.
 * Assumes producer and consumer share clk_sys.
 */
`timescale 1ns/1ps
module c8bd_buf #(
	parameter int W = 9
) (
	input logic clk_sys,
	input logic rst,
	input logic in_valid,
	input logic [W-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [W-1:0] out_data,
	input logic out_ready
);
	typedef struct packed {
		logic [W-1:0] head;
		logic head_v;
		logic [W-1:0] tail;
		logic tail_v;
		logic in_rdy;
	} c8bd_buf_st_t;

	c8bd_buf_st_t s_q;
	c8bd_buf_st_t s_d;

	always_comb begin
		s_d = s_q;
		if (s_q.head_v && out_ready) begin
			s_d.head = s_q.tail;
			s_d.head_v = s_q.tail_v;
			s_d.tail_v = 1'b0;
		end
		if (in_valid && s_q.in_rdy) begin
			if (!s_d.head_v) begin
				s_d.head = in_data;
				s_d.head_v = 1'b1;
			end else begin
				s_d.tail = in_data;
				s_d.tail_v = 1'b1;
			end
		end
		s_d.in_rdy = !s_d.tail_v;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_q <= '{head: '0, head_v: 1'b0, tail: '0, tail_v: 1'b0, in_rdy: 1'b1};
		end else begin
			s_q <= s_d;
		end
	end

	assign in_ready = s_q.in_rdy;
	assign out_valid = s_q.head_v;
	assign out_data = s_q.head;
endmodule : c8bd_buf

// ### c8bd_pkg.sv
/*
 * Constants and code tables for the 8B/10B encoder and decoder.
 * Assumes a single character-rate-by-ten clock; nothing else is shared.
 */
package c8bd_pkg;
	localparam logic [3:0] C8BD_LAST_BIT = 4'h9;
	localparam logic C8BD_RD_RST = 1'b0;
	localparam logic [4:0] C8BD_X_K28 = 5'h1c;
	localparam logic [2:0] C8BD_Y_ALT = 3'h7;
	localparam logic [7:0] C8BD_K28_5 = 8'hbc;
	// Forcing codes C1.7 and C2.7
	localparam logic [7:0] C8BD_FORCE_NEG = 8'he1;
	localparam logic [7:0] C8BD_FORCE_POS = 8'he2;
	localparam logic [5:0] C8BD_K28_S6 = 6'h0f;
	localparam logic [5:0] C8BD_BAL6_POS = 6'h07;
	localparam logic [5:0] C8BD_BAL6_NEG = 6'h38;
	localparam logic [3:0] C8BD_BAL4_POS = 4'h3;
	localparam logic [3:0] C8BD_BAL4_NEG = 4'hc;
	localparam logic [3:0] C8BD_ALT4 = 4'h7;
	localparam logic [6:0] C8BD_COMMA = 7'h1f;
	// Five-bit values whose .7 uses the alternate fghj
	localparam logic [31:0] C8BD_KALT_SET = 32'h68800000;
	localparam logic [31:0] C8BD_DALT_NEG = 32'h00160000;
	localparam logic [31:0] C8BD_DALT_POS = 32'h00006800;
	// abcdei and fghj for negative disparity
	localparam logic [5:0] C8BD_TAB6 [0:31] = '{
		6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
		6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
		6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
		6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
	localparam logic [3:0] C8BD_TAB4 [0:7] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
endpackage : c8bd_pkg

// ### c8bd_remote.sv
/*
 * Far-side transceiver model: sends queued 10-bit characters, K28.5 when idle.
 * Assumes the bench pushes characters into q with bit a in bit 9.
 */
`timescale 1ns/1ps
module c8bd_remote (
	input logic clk_sys,
	input logic rst,
	output logic rx_serial
);
	logic [9:0] q[$];
	logic [9:0] sh;
	logic rd;
	int n;
	function automatic logic end_rd(logic r, logic [9:0] c);
		int a;
		int b;
		a = $countones(c[9:4]);
		b = $countones(c[3:0]);
		r = (a > 3 || c[9:4] == 6'h07) ? 1'b1 : (a < 3 || c[9:4] == 6'h38) ? 1'b0 : r;
		return (b > 2 || c[3:0] == 4'h3) ? 1'b1 : (b < 2 || c[3:0] == 4'hc) ? 1'b0 : r;
	endfunction : end_rd
	always @(posedge clk_sys) begin
		if (rst) begin
			n <= 0;
			rd <= 1'b0;
			rx_serial <= 1'b0;
		end else begin
			if (n == 0) begin
				sh = (q.size() > 0) ? q.pop_front() : (rd ? 10'h305 : 10'h0fa);
				rd <= end_rd(rd, sh);
			end
			rx_serial <= sh[9 - n];
			n <= (n == 9) ? 0 : n + 1;
		end
	end
endmodule : c8bd_remote

// ### c8bd_sync.sv
/*
 * Two-flop synchroniser for the serial receive pin.
 * Assumes the input is asynchronous to clk_sys.
 */
`timescale 1ns/1ps
module c8bd_sync (
	input logic clk_sys,
	input logic rst,
	input logic din,
	output logic dout
);
	typedef struct packed {
		logic meta;
		logic sync;
	} c8bd_sync_st_t;

	c8bd_sync_st_t s_q;
	c8bd_sync_st_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.meta = din;
		s_d.sync = s_q.meta;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign dout = s_q.sync;
endmodule : c8bd_sync

// ### c8bd_top.sv
/*
 * 8B/10B encoder with serialiser and deserialiser with decoder, each tracking running disparity.
 * Assumes one serial bit per clk_sys cycle and rx_serial asynchronous to clk_sys.
 */
`timescale 1ns/1ps
module c8bd_top (
	input logic clk_sys,
	input logic rst,
	input logic [7:0] tx_data,
	input logic special_char_select,
	input logic tx_valid,
	output logic tx_ready,
	output logic tx_serial,
	output logic tx_frame,
	output logic tx_disp,
	input logic rx_serial,
	output logic [7:0] rx_data,
	output logic rx_special,
	output logic rx_code_err,
	output logic rx_valid,
	input logic rx_ready,
	output logic rx_aligned,
	output logic rx_disp,
	output logic rx_lost
);
	// Sub-block tables and disparity
	function automatic logic [5:0] c8bd_enc6(input logic [4:0] x, input logic rd);
		logic [5:0] t;
		t = c8bd_pkg::C8BD_TAB6[x];
		if (rd && (($countones(t) != 3) || (t == c8bd_pkg::C8BD_BAL6_NEG))) begin
			t = ~t;
		end
		return t;
	endfunction : c8bd_enc6

	function automatic logic [3:0] c8bd_enc4(input logic [2:0] y, input logic rd);
		logic [3:0] t;
		t = c8bd_pkg::C8BD_TAB4[y];
		if (rd && (($countones(t) != 2) || (t == c8bd_pkg::C8BD_BAL4_NEG))) begin
			t = ~t;
		end
		return t;
	endfunction : c8bd_enc4

	function automatic logic c8bd_disp6(input logic [5:0] sb, input logic rin);
		logic r;
		r = rin;
		if (($countones(sb) > 3) || (sb == c8bd_pkg::C8BD_BAL6_POS)) begin
			r = 1'b1;
		end else if (($countones(sb) < 3) || (sb == c8bd_pkg::C8BD_BAL6_NEG)) begin
			r = 1'b0;
		end
		return r;
	endfunction : c8bd_disp6

	function automatic logic c8bd_disp4(input logic [3:0] sb, input logic rin);
		logic r;
		r = rin;
		if (($countones(sb) > 2) || (sb == c8bd_pkg::C8BD_BAL4_POS)) begin
			r = 1'b1;
		end else if (($countones(sb) < 2) || (sb == c8bd_pkg::C8BD_BAL4_NEG)) begin
			r = 1'b0;
		end
		return r;
	endfunction : c8bd_disp4

	// Disparity at the end of a whole character
	function automatic logic c8bd_rd10(input logic [9:0] c, input logic rin);
		return c8bd_disp4(c[3:0], c8bd_disp6(c[9:4], rin));
	endfunction : c8bd_rd10

	function automatic logic c8bd_kvalid(input logic [7:0] b);
		return (b[4:0] == c8bd_pkg::C8BD_X_K28) ||
			((b[7:5] == c8bd_pkg::C8BD_Y_ALT) && c8bd_pkg::C8BD_KALT_SET[b[4:0]]);
	endfunction : c8bd_kvalid

	// Character for a byte under the given disparity; a is bit 9, j is bit 0
	function automatic logic [9:0] c8bd_enc10(input logic k, input logic [7:0] b, input logic rd);
		logic [5:0] s6;
		logic [3:0] s4;
		logic rm;
		logic k28;
		logic alt;
		k28 = k && (b[4:0] == c8bd_pkg::C8BD_X_K28);
		s6 = k28 ? (rd ? ~c8bd_pkg::C8BD_K28_S6 : c8bd_pkg::C8BD_K28_S6) : c8bd_enc6(b[4:0], rd);
		rm = c8bd_disp6(s6, rd);
		alt = (b[7:5] == c8bd_pkg::C8BD_Y_ALT) && (k || (!rm && c8bd_pkg::C8BD_DALT_NEG[b[4:0]]) ||
			(rm && c8bd_pkg::C8BD_DALT_POS[b[4:0]]));
		s4 = alt ? (rm ? ~c8bd_pkg::C8BD_ALT4 : c8bd_pkg::C8BD_ALT4) : c8bd_enc4(b[7:5], rm);
		if (k28 && !rm && ($countones(s4) == 2) && (s4 != c8bd_pkg::C8BD_BAL4_NEG) &&
			(s4 != c8bd_pkg::C8BD_BAL4_POS)) begin
			s4 = ~s4;
		end
		return {s6, s4};
	endfunction : c8bd_enc10

	// Returns {violation, special, byte}
	function automatic logic [9:0] c8bd_dec10(input logic [9:0] c, input logic rd);
		logic [5:0] s6;
		logic [3:0] t4;
		logic [4:0] x;
		logic [2:0] y;
		logic xok;
		logic yok;
		logic k;
		logic rm;
		logic err;
		s6 = c[9:4];
		x = '0;
		y = '0;
		xok = 1'b0;
		yok = 1'b0;
		k = 1'b0;
		for (int i = 0; i < 32; i++) begin
			if ((c8bd_enc6(5'(i), 1'b0) == s6) || (c8bd_enc6(5'(i), 1'b1) == s6)) begin
				x = 5'(i);
				xok = 1'b1;
			end
		end
		if ((s6 == c8bd_pkg::C8BD_K28_S6) || (s6 == ~c8bd_pkg::C8BD_K28_S6)) begin
			x = c8bd_pkg::C8BD_X_K28;
			xok = 1'b1;
			k = 1'b1;
		end
		rm = c8bd_disp6(s6, rd);
		t4 = c[3:0];
		if (k && !rm && ($countones(t4) == 2) && (t4 != c8bd_pkg::C8BD_BAL4_NEG) &&
			(t4 != c8bd_pkg::C8BD_BAL4_POS)) begin
			t4 = ~t4;
		end
		for (int j = 0; j < 8; j++) begin
			if ((c8bd_enc4(3'(j), 1'b0) == t4) || (c8bd_enc4(3'(j), 1'b1) == t4)) begin
				y = 3'(j);
				yok = 1'b1;
			end
		end
		if ((t4 == c8bd_pkg::C8BD_ALT4) || (t4 == ~c8bd_pkg::C8BD_ALT4)) begin
			y = c8bd_pkg::C8BD_Y_ALT;
			yok = 1'b1;
			k = k | c8bd_pkg::C8BD_KALT_SET[x];
		end
		// Not in the column for the current disparity
		err = !xok || !yok || (c8bd_enc10(k, {y, x}, rd) != c);
		return {err, k, y, x};
	endfunction : c8bd_dec10

	typedef struct packed {
		logic [8:0] tx_sh;
		logic [3:0] tx_cnt;
		logic tx_bit;
		logic tx_frame;
		logic tx_rd;
		logic tx_rd_in;
		logic tx_forced;
		logic tx_k;
		logic [7:0] tx_byte;
		logic [9:0] tx_char;
		logic [9:0] rx_win;
		logic [3:0] rx_cnt;
		logic rx_aligned;
		logic rx_rd;
		logic rx_push;
		logic [9:0] rx_char;
		logic [9:0] rx_word;
		logic rx_lost;
	} c8bd_top_st_t;

	c8bd_top_st_t s_q;
	c8bd_top_st_t s_d;
	logic tb_valid;
	logic [8:0] tb_data;
	logic tb_take;
	logic rx_bit;
	logic rb_in_ready;
	logic [9:0] rb_data;

	c8bd_buf #(.W(9)) u_tx_buf (
		.clk_sys(clk_sys),
		.rst(rst),
		.in_valid(tx_valid),
		.in_data({special_char_select, tx_data}),
		.in_ready(tx_ready),
		.out_valid(tb_valid),
		.out_data(tb_data),
		.out_ready(tb_take)
	);

	c8bd_sync u_rx_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.din(rx_serial),
		.dout(rx_bit)
	);

	c8bd_buf #(.W(10)) u_rx_buf (
		.clk_sys(clk_sys),
		.rst(rst),
		.in_valid(s_q.rx_push),
		.in_data(s_q.rx_word),
		.in_ready(rb_in_ready),
		.out_valid(rx_valid),
		.out_data(rb_data),
		.out_ready(rx_ready)
	);

	// A character is taken from the buffer on the last bit of the previous one
	assign tb_take = (s_q.tx_cnt == c8bd_pkg::C8BD_LAST_BIT);

	always_comb begin
		logic [9:0] c;
		logic [7:0] b;
		logic k;
		logic rd;
		logic comma;
		logic dec;
		logic [9:0] win;
		c = '0;
		b = c8bd_pkg::C8BD_K28_5;
		k = 1'b1;
		rd = s_q.tx_rd;
		s_d = s_q;
		s_d.tx_frame = 1'b0;
		s_d.tx_forced = 1'b0;
		if (tb_take) begin
			// Idle fill is a comma character
			if (tb_valid) begin
				k = tb_data[8];
				b = tb_data[7:0];
				if (k && (tb_data[7:0] == c8bd_pkg::C8BD_FORCE_NEG)) begin
					b = c8bd_pkg::C8BD_K28_5;
					rd = 1'b0;
					s_d.tx_forced = 1'b1;
				end else if (k && (tb_data[7:0] == c8bd_pkg::C8BD_FORCE_POS)) begin
					b = c8bd_pkg::C8BD_K28_5;
					rd = 1'b1;
					s_d.tx_forced = 1'b1;
				end else if (k && !c8bd_kvalid(tb_data[7:0])) begin
					b = c8bd_pkg::C8BD_K28_5;
				end
			end
			c = c8bd_enc10(k, b, rd);
			s_d.tx_char = c;
			s_d.tx_k = k;
			s_d.tx_byte = b;
			s_d.tx_rd_in = rd;
			s_d.tx_rd = c8bd_rd10(c, rd);
			s_d.tx_bit = c[9];
			s_d.tx_sh = c[8:0];
			s_d.tx_cnt = '0;
			s_d.tx_frame = 1'b1;
		end else begin
			s_d.tx_bit = s_q.tx_sh[8];
			s_d.tx_sh = {s_q.tx_sh[7:0], 1'b0};
			s_d.tx_cnt = s_q.tx_cnt + 4'h1;
		end

		win = {s_q.rx_win[8:0], rx_bit};
		s_d.rx_win = win;
		comma = (win[9:3] == c8bd_pkg::C8BD_COMMA) || (win[9:3] == ~c8bd_pkg::C8BD_COMMA);
		s_d.rx_aligned = s_q.rx_aligned | comma;
		dec = comma || (s_q.rx_aligned && (s_q.rx_cnt == c8bd_pkg::C8BD_LAST_BIT));
		s_d.rx_cnt = (dec || (s_q.rx_cnt == c8bd_pkg::C8BD_LAST_BIT)) ? 4'h0 : s_q.rx_cnt + 4'h1;
		s_d.rx_push = dec;
		if (dec) begin
			s_d.rx_char = win;
			s_d.rx_word = c8bd_dec10(win, s_q.rx_rd);
			s_d.rx_rd = c8bd_rd10(win, s_q.rx_rd);
		end
		s_d.rx_lost = s_q.rx_push && !rb_in_ready;
	end

	// Both ends start negative
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_q <= '0;
			s_q.tx_cnt <= c8bd_pkg::C8BD_LAST_BIT;
			s_q.tx_rd <= c8bd_pkg::C8BD_RD_RST;
			s_q.rx_rd <= c8bd_pkg::C8BD_RD_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign tx_serial = s_q.tx_bit;
	assign tx_frame = s_q.tx_frame;
	assign tx_disp = s_q.tx_rd;
	assign rx_data = rb_data[7:0];
	assign rx_special = rb_data[8];
	assign rx_code_err = rb_data[9];
	assign rx_aligned = s_q.rx_aligned;
	assign rx_disp = s_q.rx_rd;
	assign rx_lost = s_q.rx_lost;

	tx_spacing_a: assert property (@(posedge clk_sys) disable iff (rst)
		s_q.tx_frame |-> ##10 s_q.tx_frame) else $error("tx character not every ten cycles");
	tx_quiet_a: assert property (@(posedge clk_sys) disable iff (rst)
		s_q.tx_frame |=> !s_q.tx_frame [*8]) else $error("tx frame marker too early");
	tx_order_a: assert property (@(posedge clk_sys) disable iff (rst)
		s_q.tx_frame |-> (s_q.tx_bit == s_q.tx_char[9]) ##5 (s_q.tx_bit == s_q.tx_char[4]))
		else $error("tx bit order wrong");
	tx_rd_a: assert property (@(posedge clk_sys) disable iff (rst)
		s_q.tx_frame |-> (s_q.tx_rd == c8bd_rd10(s_q.tx_char, s_q.tx_rd_in)))
		else $error("tx disparity not updated from character");
	tx_rd_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
		s_q.tx_frame && !s_q.tx_forced |-> (s_q.tx_rd_in == $past(s_q.tx_rd)))
		else $error("tx used wrong disparity column");
	tx_round_a: assert property (@(posedge clk_sys) disable iff (rst)
		s_q.tx_frame |-> (c8bd_dec10(s_q.tx_char, s_q.tx_rd_in) == {1'b0, s_q.tx_k, s_q.tx_byte}))
		else $error("tx character does not decode back");
	tx_balance_a: assert property (@(posedge clk_sys) disable iff (rst)
		s_q.tx_frame |-> ($countones(s_q.tx_char) inside {[4:6]}))
		else $error("tx character unbalanced");
	tx_force_a: assert property (@(posedge clk_sys) disable iff (rst)
		s_q.tx_frame && s_q.tx_forced |-> s_q.tx_k && (s_q.tx_byte == c8bd_pkg::C8BD_K28_5))
		else $error("forced code sent wrong character");
	rx_rd_a: assert property (@(posedge clk_sys) disable iff (rst)
		s_q.rx_push |-> (s_q.rx_rd == c8bd_rd10(s_q.rx_char, $past(s_q.rx_rd))))
		else $error("rx disparity not updated");
	rx_align_a: assert property (@(posedge clk_sys) disable iff (rst)
		s_q.rx_push |-> s_q.rx_aligned) else $error("rx decoded before alignment");
endmodule : c8bd_top
